// >>> lhd_consts.vh
`ifndef LHD_CONSTS_VH
`define LHD_CONSTS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define LHD_REG_CTRL 4'h0
`define LHD_REG_STATUS 4'h4
`define LHD_REG_PROG 4'h8
`define LHD_REG_RUN 4'hC

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define LHD_CTRL_GATE_FITTED 0
`define LHD_CTRL_QCW_FITTED 1
`define LHD_CTRL_RESET 8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LHD_ST_POWER 0
`define LHD_ST_GATE_OPEN 1
`define LHD_ST_GATE_LSB 2
`define LHD_ST_QCW 4
`define LHD_ST_ANALOG 5
`define LHD_ST_RUNNING 6

// ----------------------------------------
// Gate selection codes
// ----------------------------------------
`define LHD_GATE_CLOSE 4'h0
`define LHD_GATE_ONE 4'h1
`define LHD_GATE_TWO 4'h2
`define LHD_GATE_THREE 4'h3

// ----------------------------------------
// Widths
// ----------------------------------------
`define LHD_PROG_W 7
`define LHD_SYNC_W 14

`endif

// >>> lhd_sync.v
`timescale 1ns/100ps
// Two-stage synchroniser for a bundle of levels
module lhd_sync #(
   parameter W = 1
) (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   // First stage read only by second stage
   always @(posedge clk_i) begin
      if (rst_i) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else if (ce_i) begin
         meta_reg <= d_i;
         sync_reg <= meta_reg;
      end
   end

   assign q_o = sync_reg;
endmodule // lhd_sync

// >>> lhd_edge.v
`timescale 1ns/100ps
// Rising and falling edge detector on a synchronised level
module lhd_edge (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire d_i,
   output wire rise_o,
   output wire fall_o
);
   reg prev_reg;

   // Previous sample
   always @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= 1'b0;
      end else if (ce_i) begin
         prev_reg <= d_i;
      end
   end

   assign rise_o = ce_i & d_i & ~prev_reg;
   assign fall_o = ce_i & ~d_i & prev_reg;
endmodule // lhd_edge

// >>> lhd_decoder.v
// Behaviour
// RULE1: The seven program lines form a number with the lowest line as bit zero and the rest as bits one to six.
// RULE2: A rising edge on the drive power request switches the main drive power on.
// RULE3: A falling edge on the drive power request switches the main drive power off.
// RULE4: Gate code 0000 closes the gate and 0001, 0010, 0011 open gate one, two and three.
// RULE5: The first gate line is the least and the fourth the most significant bit of the code.
// RULE6: Gate decode acts only on gate-fitted units and the lines are ignored otherwise.
// RULE7: The pulsed mode enable acts only on units with that mode and is reserved otherwise.
// RULE8: A rising edge on the execute trigger runs the stored program whose index is the program number.
// RULE9: Program zero with analog select high sets power from the analog value instead of a program.
// RULE10: Every control input passes two synchronising flip-flops before edge detection or decoding.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "lhd_consts.vh"

module lhd_decoder (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [3:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Controller lines
   input wire prog_num_bit0_i,
   input wire [5:0] prog_num_bits_high_i,
   input wire drive_power_request_i,
   input wire [3:0] gate_select_code_i,
   input wire pulsed_mode_enable_i,
   input wire program_execute_trigger_i,
   input wire analog_power_select_i,
   // Decoded outputs
   output reg main_power_on_o,
   output reg gate_open_o,
   output reg [1:0] gate_index_o,
   output reg pulsed_mode_o,
   output reg analog_mode_o,
   output reg program_start_o,
   output reg [6:0] program_index_o
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Synchronised fields and edge strobes
   wire [13:0] raw_in;
   wire [13:0] syn;
   wire [6:0] prog_num;
   wire [3:0] gate_code;
   wire pwr_req;
   wire qcw_req;
   wire exec_req;
   wire analog_req;
   wire pwr_rise;
   wire pwr_fall;
   wire exec_rise;
   wire exec_fall;

   // Raw lines gathered into one bundle
   assign raw_in = {analog_power_select_i, program_execute_trigger_i, pulsed_mode_enable_i,
                    drive_power_request_i, gate_select_code_i, prog_num_bits_high_i};

   // Two flops on every control line except program bit zero
   lhd_sync #(.W(`LHD_SYNC_W)) u_sync_ctl ( // see RULE10
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(raw_in),
      .q_o(syn)
   );

   // Program bit zero on a synchroniser of its own
   wire prog0_syn;
   lhd_sync #(.W(1)) u_sync_bit0 ( // see RULE10
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(prog_num_bit0_i),
      .q_o(prog0_syn)
   );

   // Field split, lowest line as bit zero
   assign prog_num = {syn[5:0], prog0_syn}; // see RULE1
   assign gate_code = syn[9:6]; // see RULE5
   assign pwr_req = syn[10];
   assign qcw_req = syn[11];
   assign exec_req = syn[12];
   assign analog_req = syn[13];

   // ----------------------------------------
   // Edge detection
   // ----------------------------------------
   // Drive power request edges
   lhd_edge u_edge_pwr (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(pwr_req),
      .rise_o(pwr_rise),
      .fall_o(pwr_fall)
   );

   // Execute trigger edges; the fall ends the run
   lhd_edge u_edge_exec (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .d_i(exec_req),
      .rise_o(exec_rise),
      .fall_o(exec_fall)
   );

   // ----------------------------------------
   // Control register and run counter
   // ----------------------------------------
   // Option flags, run count and running state
   reg [7:0] ctrl_reg;
   reg [15:0] run_count_reg;
   reg running_reg;
   wire gate_fitted;
   wire qcw_fitted;
   wire bus_req;

   // Fitted options and a request not yet answered
   assign gate_fitted = ctrl_reg[`LHD_CTRL_GATE_FITTED];
   assign qcw_fitted = ctrl_reg[`LHD_CTRL_QCW_FITTED];
   assign bus_req = cyc_i & stb_i & ~ack_o;

   // ----------------------------------------
   // Main power switching
   // ----------------------------------------
   reg main_power_next;

   // Request edges switch power, a level alone changes nothing
   always @* begin
      main_power_next = main_power_on_o;
      if (pwr_rise) begin
         main_power_next = 1'b1; // see RULE2
      end else if (pwr_fall) begin
         main_power_next = 1'b0; // see RULE3
      end
   end

   // Power state register
   always @(posedge clk_i) begin
      if (rst_i) begin
         main_power_on_o <= 1'b0;
      end else if (ce_i) begin
         main_power_on_o <= main_power_next;
      end
   end

   // ----------------------------------------
   // Gate decode and pulsed mode
   // ----------------------------------------
   reg gate_open_next;
   reg [1:0] gate_index_next;

   // Code to open flag and index; standard units keep the gate shut
   always @* begin
      gate_open_next = 1'b0;
      gate_index_next = 2'h0;
      if (gate_fitted) begin // see RULE6
         case (gate_code) // see RULE4
            `LHD_GATE_CLOSE: begin
               gate_open_next = 1'b0;
               gate_index_next = 2'h0;
            end
            `LHD_GATE_ONE: begin
               gate_open_next = 1'b1;
               gate_index_next = 2'h1;
            end
            `LHD_GATE_TWO: begin
               gate_open_next = 1'b1;
               gate_index_next = 2'h2;
            end
            `LHD_GATE_THREE: begin
               gate_open_next = 1'b1;
               gate_index_next = 2'h3;
            end
            default: begin
               // Undefined codes shut the gate
               gate_open_next = 1'b0;
               gate_index_next = 2'h0;
            end
         endcase
      end
   end

   // Registered gate state and pulsed mode level
   always @(posedge clk_i) begin
      if (rst_i) begin
         gate_open_o <= 1'b0;
         gate_index_o <= 2'h0;
         pulsed_mode_o <= 1'b0;
      end else if (ce_i) begin
         gate_open_o <= gate_open_next;
         gate_index_o <= gate_index_next;
         pulsed_mode_o <= qcw_fitted & qcw_req; // see RULE7
      end
   end

   // ----------------------------------------
   // Program execution and analog mode
   // ----------------------------------------
   wire analog_pick;

   // Program zero with analog select takes power from the analog input
   assign analog_pick = (prog_num == 7'h00) & analog_req; // see RULE9

   // Start pulse, index capture, run count and running flag
   always @(posedge clk_i) begin
      if (rst_i) begin
         program_start_o <= 1'b0;
         program_index_o <= 7'h00;
         analog_mode_o <= 1'b0;
         running_reg <= 1'b0;
         run_count_reg <= 16'h0000;
      end else if (ce_i) begin
         program_start_o <= 1'b0;
         if (exec_rise) begin
            running_reg <= 1'b1;
            run_count_reg <= run_count_reg + 16'h0001;
            if (analog_pick) begin
               analog_mode_o <= 1'b1; // see RULE9
            end else begin
               // Stored program: pulse start and latch the index
               analog_mode_o <= 1'b0;
               program_start_o <= 1'b1; // see RULE8
               program_index_o <= prog_num; // see RULE8
            end
         end else if (exec_fall) begin
            running_reg <= 1'b0;
            analog_mode_o <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Register read multiplexer
   // ----------------------------------------
   reg [31:0] status_word;
   reg [31:0] rd_word;
   wire ctrl_wr;

   // Status fields placed at their bit positions
   always @* begin
      status_word = 32'h00000000;
      status_word[`LHD_ST_POWER] = main_power_on_o;
      status_word[`LHD_ST_GATE_OPEN] = gate_open_o;
      status_word[`LHD_ST_GATE_LSB +: 2] = gate_index_o;
      status_word[`LHD_ST_QCW] = pulsed_mode_o;
      status_word[`LHD_ST_ANALOG] = analog_mode_o;
      status_word[`LHD_ST_RUNNING] = running_reg;
   end

   // Addressed register, zero for unmapped offsets
   always @* begin
      rd_word = 32'h00000000;
      case (adr_i)
         `LHD_REG_CTRL: begin
            rd_word = {24'h000000, ctrl_reg};
         end
         `LHD_REG_STATUS: begin
            rd_word = status_word;
         end
         `LHD_REG_PROG: begin
            rd_word = {21'h000000, gate_code, prog_num};
         end
         `LHD_REG_RUN: begin
            rd_word = {16'h0000, run_count_reg};
         end
         default: begin
            rd_word = 32'h00000000;
         end
      endcase
   end

   // ----------------------------------------
   // Wishbone slave, ack one cycle after the request
   // ----------------------------------------
   // Write lands on the edge where the master sees ack high
   assign ctrl_wr = ack_o & cyc_i & stb_i & we_i & sel_i[0] & (adr_i == `LHD_REG_CTRL);

   // Registered ack and read data; ack masks a second take
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
         ctrl_reg <= `LHD_CTRL_RESET;
      end else if (ce_i) begin
         ack_o <= bus_req;
         if (bus_req) begin
            dat_o <= rd_word;
         end
         if (ctrl_wr) begin
            ctrl_reg <= dat_i[7:0];
         end
      end
   end

endmodule // lhd_decoder

// >>> lhd_decoder_props.sv
`timescale 1ns/100ps
// Port checker for the hardwired line decoder
module lhd_decoder_props (
   input wire clk_i,
   input wire rst_i,
   input wire ce_i,
   input wire cyc_i,
   input wire stb_i,
   input wire ack_o,
   input wire prog_num_bit0_i,
   input wire [5:0] prog_num_bits_high_i,
   input wire drive_power_request_i,
   input wire [3:0] gate_select_code_i,
   input wire pulsed_mode_enable_i,
   input wire analog_power_select_i,
   input wire main_power_on_o,
   input wire gate_open_o,
   input wire [1:0] gate_index_o,
   input wire pulsed_mode_o,
   input wire analog_mode_o,
   input wire program_start_o,
   input wire [6:0] program_index_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire [6:0] num = {prog_num_bits_high_i, prog_num_bit0_i};
   wire gate_shut = gate_select_code_i == 4'h0 || gate_select_code_i > 4'h3;
   // ----------------------------------------
   // Bus and decoded outputs
   // ----------------------------------------
   AST_ACK: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o ##1 !ack_o) // Bus handshake
      else $error("ack not a single pulse after request");
   AST_SYNC_LAT: assert property ($rose(drive_power_request_i) && !main_power_on_o |=> !main_power_on_o [*2])
      else $error("power switched before two sync stages");
   AST_PWR_ON: assert property ($rose(drive_power_request_i) |-> ##[1:4] main_power_on_o)
      else $error("power did not switch on");
   AST_PWR_OFF: assert property ($fell(drive_power_request_i) |-> ##[1:4] !main_power_on_o)
      else $error("power did not switch off");
   AST_PWR_CAUSE: assert property ($rose(main_power_on_o) |-> $past(drive_power_request_i))
      else $error("power on without request");
   AST_GATE_IDX: assert property (gate_open_o == (gate_index_o != 2'h0))
      else $error("gate index and open flag disagree");
   AST_GATE_SHUT: assert property (gate_shut [*4] |-> !gate_open_o)
      else $error("gate open on a closing code");
   AST_QCW: assert property (!pulsed_mode_enable_i [*4] |-> !pulsed_mode_o)
      else $error("pulsed mode without enable");
   AST_START_IDX: assert property (program_start_o |-> program_index_o == num)
      else $error("program index differs from lines");
   AST_START_PULSE: assert property (program_start_o |=> !program_start_o)
      else $error("start pulse longer than one cycle");
   AST_ANALOG: assert property ($rose(analog_mode_o) |-> !program_start_o && analog_power_select_i && num == 7'h00)
      else $error("analog mode on wrong condition");
   cover property ($rose(main_power_on_o));
   cover property (program_start_o);
   cover property ($rose(analog_mode_o));
   cover property (gate_open_o && gate_index_o == 2'h3);
endmodule // lhd_decoder_props

bind lhd_decoder lhd_decoder_props i_lhd_decoder_props (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .ack_o,
   .prog_num_bit0_i, .prog_num_bits_high_i, .drive_power_request_i, .gate_select_code_i, .pulsed_mode_enable_i,
   .analog_power_select_i, .main_power_on_o, .gate_open_o, .gate_index_o, .pulsed_mode_o, .analog_mode_o,
   .program_start_o, .program_index_o);

// >>> lhd_ctl_model.sv
`timescale 1ns/100ps
// Machine controller model: drives the hardwired lines
module lhd_ctl_model (
   input wire clk_i,
   input wire [6:0] num_i,
   input wire [3:0] gate_i,
   input wire [3:0] misc_i, // Power, pulsed, execute, analog
   output reg p0_o,
   output reg [5:0] ph_o,
   output reg pwr_o,
   output reg [3:0] gs_o,
   output reg qcw_o,
   output reg exe_o,
   output reg ana_o
);
   initial {ph_o, p0_o, gs_o, pwr_o, qcw_o, exe_o, ana_o} = 15'h0000;
   // Lines change just after the edge
   always @(posedge clk_i) begin
      {ph_o, p0_o} <= num_i;
      gs_o <= gate_i;
      {pwr_o, qcw_o, exe_o, ana_o} <= misc_i;
   end
endmodule // lhd_ctl_model

// >>> testbench.sv
`timescale 1ns/100ps
`include "lhd_consts.vh"
module testbench;
   reg clk_i = 1'b0;
   reg rst_i = 1'b1;
   reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
   reg [3:0] adr = 4'h0, gate = 4'h0, misc = 4'h0;
   reg [31:0] dat = 32'h0, q, r;
   reg [6:0] num = 7'h00, last_idx = 7'h00;
   wire [31:0] dat_o;
   wire ack_o, p0, pwr, qcw, exe, ana, pon, gop, pm, am, ps;
   wire [5:0] ph;
   wire [3:0] gs;
   wire [1:0] gi;
   wire [6:0] pi;
   integer failures = 0, compares = 0, ticks = 0, starts = 0, i;
   always #5 clk_i = ~clk_i;
   lhd_ctl_model i_lhd_ctl_model (.clk_i(clk_i), .num_i(num), .gate_i(gate), .misc_i(misc), .p0_o(p0), .ph_o(ph),
      .pwr_o(pwr), .gs_o(gs), .qcw_o(qcw), .exe_o(exe), .ana_o(ana));
   lhd_decoder i_lhd_decoder (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
      .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .prog_num_bit0_i(p0),
      .prog_num_bits_high_i(ph), .drive_power_request_i(pwr), .gate_select_code_i(gs), .pulsed_mode_enable_i(qcw),
      .program_execute_trigger_i(exe), .analog_power_select_i(ana), .main_power_on_o(pon), .gate_open_o(gop),
      .gate_index_o(gi), .pulsed_mode_o(pm), .analog_mode_o(am), .program_start_o(ps), .program_index_o(pi));
   // Expected open flag and index for a gate code
   function [2:0] gexp(input [3:0] c);
      gexp = (c != 4'h0 && c < 4'h4) ? {1'b1, c[1:0]} : 3'h0;
   endfunction
   task chk(input string n, input [31:0] s, input [31:0] e);
      compares = compares + 1;
      if (s !== e) begin
         failures = failures + 1;
         $display("Error %0s expected %h seen %h", n, e, s);
      end
   endtask
   task step(input integer n);
      repeat (n) @(posedge clk_i);
   endtask
   // Classic single Wishbone cycle
   task wb(input w, input [3:0] a, input [31:0] d);
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task print_verdict;
      $display("Comparisons %0d mismatches %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Start pulse monitor and timeout
   always @(posedge clk_i) begin
      ticks = ticks + 1;
      if (ps === 1'b1) begin
         starts = starts + 1;
         last_idx = pi;
      end
      if (ticks == 5000) begin
         failures = failures + 1;
         print_verdict;
      end
   end
   initial begin
      i = $urandom(32'hBE19);
      step(8);
      rst_i <= 1'b0;
      wb(1'b0, `LHD_REG_CTRL, 32'h00000000);
      chk("ctrl", q, 0);
      wb(1'b1, 4'h2, 32'hFFFFFFFF);
      wb(1'b0, 4'h2, 32'h00000000);
      chk("unmapped", q, 0);
      // Gate and pulsed lines on a plain unit
      gate <= 4'h2;
      misc <= 4'h4;
      step(6);
      chk("gate plain", gop, 0);
      chk("pulsed plain", pm, 0);
      wb(1'b1, `LHD_REG_CTRL, 32'h00000003);
      step(6);
      chk("pulsed", pm, 1);
      for (i = 0; i < 16; i = i + 1) begin
         gate <= i[3:0];
         step(6);
         chk("gate", {gop, gi}, gexp(i[3:0]));
      end
      misc <= 4'h8;
      step(6);
      chk("power on", pon, 1);
      wb(1'b0, `LHD_REG_STATUS, 32'h00000000);
      chk("status on", q, 32'h00000001);
      misc <= 4'h0;
      step(6);
      chk("power off", pon, 0);
      // Program numbers, analog case first
      for (i = 0; i < 8; i = i + 1) begin
         r = $urandom_range(127, 1);
         num <= (i == 0) ? 7'h00 : (i == 1) ? 7'h7F : r[6:0];
         misc <= {3'b000, i == 0};
         step(5);
         misc[1] <= 1'b1;
         step(6);
         chk("starts", starts, i);
         if (i == 0) chk("analog", am, 1);
         else chk("index", last_idx, num);
         wb(1'b0, `LHD_REG_PROG, 32'h00000000);
         chk("prog", q, {21'h000000, gate, num});
         wb(1'b0, `LHD_REG_STATUS, 32'h00000000);
         chk("status run", q, {25'h0000000, 1'b1, i == 0, 5'h00});
         misc[1] <= 1'b0;
         step(5);
      end
      wb(1'b0, `LHD_REG_RUN, 32'h00000000);
      chk("runs", q[15:0], 8);
      print_verdict;
   end
endmodule // testbench
